// ---- verilog/rcp_pkg.sv ----
// Constants and types shared by the repeater control port command logic.
`default_nettype none

package rcp_pkg;

  // Port counts and LED target indices.
  localparam int unsigned NUM_PAIR   = 4;
  localparam int unsigned NUM_LED    = 6;
  localparam int unsigned LED_AUI    = 4;
  localparam int unsigned LED_GLOBAL = 5;

  // Command opcodes in the upper nibble of a command byte.
  localparam logic [3:0] OP_STATUS  = 4'h8;
  localparam logic [3:0] OP_LED_OFF = 4'h9;
  localparam logic [3:0] OP_LED_A   = 4'hB;
  localparam logic [3:0] OP_LED_B   = 4'hC;
  localparam logic [3:0] OP_RATE    = 4'hE;

  // LED target codes in the lower nibble.
  localparam logic [3:0] TGT_AUI      = 4'h8;
  localparam logic [3:0] TGT_ALL_PAIR = 4'hB;
  localparam logic [3:0] TGT_ALL      = 4'hC;
  localparam logic [3:0] TGT_GLOBAL   = 4'hD;

  // Field positions inside command and status bytes.
  localparam int unsigned CMD_RATE_SEL_BIT = 3;
  localparam int unsigned CMD_CLR_B_BIT    = 2;
  localparam int unsigned CMD_CLR_SL_BIT   = 1;
  localparam int unsigned STAT_P_BIT       = 7;
  localparam int unsigned STAT_B_BIT       = 6;
  localparam int unsigned STAT_S_BIT       = 5;
  localparam int unsigned STAT_L_BIT       = 4;

  typedef enum logic [1:0] {RATE_OFF, RATE_SLOW, RATE_FAST, RATE_SOLID} rcp_rate_e;

  // Values after reset.
  localparam logic      LINK_TEST_RST = 1'b1;
  localparam logic      LINK_PULSE_RST = 1'b1;
  localparam logic      POL_CORR_RST  = 1'b1;
  localparam logic      EXT_DIST_RST  = 1'b0;
  localparam logic      OVR_RST       = 1'b0;
  localparam rcp_rate_e RATE_RST      = RATE_OFF;

  // Blink timing: each period is split in two equal halves.
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned BLINK_SLOW_MS       = 512;
  localparam int unsigned BLINK_FAST_MS       = 1560;
  localparam int unsigned BLINK_SLOW_HALF_CYC = BLINK_SLOW_MS * (CLK_HZ / 1000) / 2;
  localparam int unsigned BLINK_FAST_HALF_CYC = BLINK_FAST_MS * (CLK_HZ / 1000) / 2;
  localparam int unsigned BLINK_CNT_W         = 24;

endpackage

`default_nettype wire

// ---- verilog/rcp_link_if.sv ----
// Internal carrier between the command core, the serial shifter and the blink generator.
`default_nettype none

interface rcp_link_if;
  import rcp_pkg::*;

  logic      cmd_vld;
  logic [7:0] cmd_byte;
  logic      rsp_load;
  logic [7:0] rsp_byte;
  rcp_rate_e rate;
  logic      blink_on;

  modport ctl (input cmd_vld, input cmd_byte, output rsp_load, output rsp_byte, output rate, input blink_on);
  modport shf (output cmd_vld, output cmd_byte, input rsp_load, input rsp_byte);
  modport blk (input rate, output blink_on);
endinterface

`default_nettype wire

// ---- verilog/rcp_serial_shift.sv ----
// Serial control port shifter: bytes in and out, least significant bit first.
`default_nettype none

module rcp_serial_shift
  import rcp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ser_clk,
  input  wire logic ser_din,
  input  wire logic ser_sel_b,
  output logic      ser_dout,
  rcp_link_if.shf   lnk
);

  logic       clk_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] in_reg;
  logic [7:0] out_reg;
  logic       rise;
  logic       fall;

  assign rise = ser_clk & ~clk_prev_reg;
  assign fall = ~ser_clk & clk_prev_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      clk_prev_reg <= 1'b0;
    else
      clk_prev_reg <= ser_clk;
  end

  // A deselected port drops any partial byte so framing always restarts cleanly.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt_reg  <= 3'h0;
      in_reg       <= 8'h00;
      lnk.cmd_vld  <= 1'b0;
      lnk.cmd_byte <= 8'h00;
    end
    else
    begin
      lnk.cmd_vld <= 1'b0;
      if (ser_sel_b)
        bit_cnt_reg <= 3'h0;
      else if (rise)
      begin
        in_reg      <= {ser_din, in_reg[7:1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7)
        begin
          lnk.cmd_vld  <= 1'b1;
          lnk.cmd_byte <= {ser_din, in_reg[7:1]};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_reg  <= 8'h00;
      ser_dout <= 1'b0;
    end
    else if (lnk.rsp_load)
      out_reg <= lnk.rsp_byte;
    else if (fall && !ser_sel_b)
    begin
      ser_dout <= out_reg[0];
      out_reg  <= {1'b0, out_reg[7:1]};
    end
  end

endmodule

`default_nettype wire

// ---- verilog/rcp_blink_gen.sv ----
// Blink phase generator for software-overridden LEDs.
`default_nettype none

module rcp_blink_gen
  import rcp_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = BLINK_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = BLINK_FAST_HALF_CYC
)
(
  input  wire logic mclk,
  input  wire logic rst_b,
  rcp_link_if.blk   lnk
);

  logic [BLINK_CNT_W-1:0] cnt_reg;
  logic [BLINK_CNT_W-1:0] half_last;
  logic                   phase_reg;
  rcp_rate_e              rate_prev_reg;

  assign half_last = (lnk.rate == RATE_FAST) ? BLINK_CNT_W'(FAST_HALF_CYC - 1) : BLINK_CNT_W'(SLOW_HALF_CYC - 1);

  // A new rate restarts the period so the first half after a change has full length.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg       <= '0;
      phase_reg     <= 1'b0;
      rate_prev_reg <= RATE_RST;
    end
    else
    begin
      rate_prev_reg <= lnk.rate;
      if (lnk.rate != rate_prev_reg || lnk.rate == RATE_OFF || lnk.rate == RATE_SOLID)
      begin
        cnt_reg   <= '0;
        phase_reg <= 1'b1;
      end
      else if (cnt_reg >= half_last)
      begin
        cnt_reg   <= '0;
        phase_reg <= ~phase_reg;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_comb
  begin
    unique case (lnk.rate)
      RATE_OFF:   lnk.blink_on = 1'b0;
      RATE_SOLID: lnk.blink_on = 1'b1;
      RATE_SLOW,
      RATE_FAST:  lnk.blink_on = phase_reg;
    endcase
  end

endmodule

`default_nettype wire

// ---- verilog/rcp_ctrl_port.sv ----
// Repeater control port command interpreter: per-pair options, LED override and attachment status.
//
// Notes on behaviour
// - Link test enable command turns checking on.
// - Link pulse disable stops pulses on pair.
// - Link pulse enable resumes pulses on pair.
// - Polarity correction disable stops correcting that pair.
// - Command input level at reset sets correction.
// - Enabled correction inverts receiver on reversed polarity.
// - Extended distance disable restores normal squelch.
// - Extended distance enable lowers squelch; off at reset.
// - Two low command bits select pair.
// - LED target decode; reserved codes select nothing.
// - Override disable returns LEDs to attributes.
// - No LED override after reset.
// - Bank A override blinks at last rate.
// - Bank B override blinks at last rate.
// - Rate code picks off, slow, fast, solid.
// - Blink rate is off after reset.
// - Status byte carries connect bit then flags.
// - Bit rate error flag sticky, read clears.
// - Serial bytes move least significant bit first.
// - Signal quality error flag sticky, read clears.
`default_nettype none

module rcp_ctrl_port
  import rcp_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = BLINK_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = BLINK_FAST_HALF_CYC
)
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                ser_clk,
  input  wire logic                ser_din,
  input  wire logic                ser_sel_b,
  output logic                     ser_dout,
  input  wire logic [NUM_PAIR-1:0] pair_link_pass,
  input  wire logic [NUM_PAIR-1:0] pair_pol_reversed,
  input  wire logic                aui_connected,
  input  wire logic                aui_rate_err_evt,
  input  wire logic                aui_sqe_err_evt,
  input  wire logic                aui_loop_err_evt,
  input  wire logic [NUM_LED-1:0]  led_a_attr,
  input  wire logic [NUM_LED-1:0]  led_b_attr,
  output logic [NUM_PAIR-1:0]      link_test_en,
  output logic [NUM_PAIR-1:0]      link_pulse_en,
  output logic [NUM_PAIR-1:0]      pol_corr_en,
  output logic [NUM_PAIR-1:0]      ext_dist_en,
  output logic [NUM_PAIR-1:0]      pair_rx_invert,
  output logic [NUM_PAIR-1:0]      pair_disconnect,
  output logic [NUM_LED-1:0]       led_a_oe,
  output logic [NUM_LED-1:0]       led_b_oe,
  output logic [1:0]               blink_rate
);

  rcp_link_if lnk ();

  logic [NUM_PAIR-1:0] link_test_reg;
  logic [NUM_PAIR-1:0] link_pulse_reg;
  logic [NUM_PAIR-1:0] pol_corr_reg;
  logic [NUM_PAIR-1:0] ext_dist_reg;
  logic [NUM_PAIR-1:0] link_test_next;
  logic [NUM_PAIR-1:0] link_pulse_next;
  logic [NUM_PAIR-1:0] pol_corr_next;
  logic [NUM_PAIR-1:0] ext_dist_next;
  logic [NUM_PAIR-1:0] rx_invert_reg;
  logic [NUM_PAIR-1:0] disconnect_reg;
  logic                strap_done_reg;
  logic [NUM_LED-1:0]  ovr_a_reg;
  logic [NUM_LED-1:0]  ovr_b_reg;
  logic [NUM_LED-1:0]  led_a_reg;
  logic [NUM_LED-1:0]  led_b_reg;
  logic [NUM_LED-1:0]  tgt_mask;
  rcp_rate_e           rate_reg;
  logic                rate_err_reg;
  logic                sqe_err_reg;
  logic                loop_err_reg;
  logic [7:0]          attachment_status_flags;
  logic [3:0]          op;
  logic                pair_cmd;
  logic                status_cmd;
  logic                rate_cmd;

  // Target decode shared by the three LED override commands.
  function automatic logic [NUM_LED-1:0] led_target(input logic [3:0] code);
    logic [NUM_LED-1:0] m;
    m = '0;
    if (code[3:2] == 2'b00)
      m[code[1:0]] = 1'b1;
    else if (code == TGT_AUI)
      m[LED_AUI] = 1'b1;
    else if (code == TGT_ALL_PAIR)
      m[NUM_PAIR-1:0] = '1;
    else if (code == TGT_ALL)
      m[LED_AUI:0] = '1;
    else if (code == TGT_GLOBAL)
      m[LED_GLOBAL] = 1'b1;
    return m;
  endfunction

  // Per-pair option commands occupy 0100 through 0111 with bit 2 clear.
  function automatic logic is_pair_cmd(input logic [7:0] c);
    return (c[7:6] == 2'b01) && !c[2];
  endfunction

  assign op         = lnk.cmd_byte[7:4];
  assign pair_cmd   = lnk.cmd_vld && is_pair_cmd(lnk.cmd_byte);
  assign rate_cmd   = lnk.cmd_vld && op == OP_RATE && lnk.cmd_byte[CMD_RATE_SEL_BIT] && !lnk.cmd_byte[2];
  assign status_cmd = lnk.cmd_vld && op == OP_STATUS && lnk.cmd_byte[3] && lnk.cmd_byte[0];
  assign tgt_mask   = led_target(lnk.cmd_byte[3:0]);

  rcp_serial_shift u_shift (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ser_clk   (ser_clk),
    .ser_din   (ser_din),
    .ser_sel_b (ser_sel_b),
    .ser_dout  (ser_dout),
    .lnk       (lnk.shf)
  );

  rcp_blink_gen #(
    .SLOW_HALF_CYC (SLOW_HALF_CYC),
    .FAST_HALF_CYC (FAST_HALF_CYC)
  ) u_blink (
    .mclk  (mclk),
    .rst_b (rst_b),
    .lnk   (lnk.blk)
  );

  // Bit 4 carries the new value; bits 5 and 3 name which option is written.
  for (genvar gi = 0; gi < NUM_PAIR; gi++)
  begin : g_pair
    logic hit;
    assign hit = pair_cmd && lnk.cmd_byte[1:0] == 2'(gi);
    assign link_test_next[gi] = (hit && {lnk.cmd_byte[5], lnk.cmd_byte[3]} == 2'b00) ? lnk.cmd_byte[4]
                                                                                      : link_test_reg[gi];
    assign link_pulse_next[gi] = (hit && {lnk.cmd_byte[5], lnk.cmd_byte[3]} == 2'b01) ? lnk.cmd_byte[4]
                                                                                       : link_pulse_reg[gi];
    assign pol_corr_next[gi] = (hit && {lnk.cmd_byte[5], lnk.cmd_byte[3]} == 2'b10) ? lnk.cmd_byte[4]
                                                                                     : pol_corr_reg[gi];
    assign ext_dist_next[gi] = (hit && {lnk.cmd_byte[5], lnk.cmd_byte[3]} == 2'b11) ? lnk.cmd_byte[4]
                                                                                     : ext_dist_reg[gi];
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_test_reg  <= {NUM_PAIR{LINK_TEST_RST}};
      link_pulse_reg <= {NUM_PAIR{LINK_PULSE_RST}};
      ext_dist_reg   <= {NUM_PAIR{EXT_DIST_RST}};
    end
    else
    begin
      link_test_reg  <= link_test_next;
      link_pulse_reg <= link_pulse_next;
      ext_dist_reg   <= ext_dist_next;
    end
  end

  // The strap is caught on the first clock after release, never by the reset itself.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_done_reg <= 1'b0;
      pol_corr_reg   <= {NUM_PAIR{POL_CORR_RST}};
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      pol_corr_reg   <= {NUM_PAIR{~ser_din}};
    end
    else
      pol_corr_reg <= pol_corr_next;
  end

  // Once inverted the receiver stays inverted; only turning correction off undoes it.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rx_invert_reg <= '0;
    else
      rx_invert_reg <= pol_corr_reg & (rx_invert_reg | pair_pol_reversed);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      disconnect_reg <= '0;
    else
      disconnect_reg <= link_test_reg & ~pair_link_pass;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rate_reg <= RATE_RST;
    else if (rate_cmd)
      rate_reg <= rcp_rate_e'(lnk.cmd_byte[1:0]);
  end

  // Disable clears both banks for the target, since one command covers a port's LEDs.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovr_a_reg <= {NUM_LED{OVR_RST}};
      ovr_b_reg <= {NUM_LED{OVR_RST}};
    end
    else if (lnk.cmd_vld)
    begin
      unique case (op)
        OP_LED_OFF:
        begin
          ovr_a_reg <= ovr_a_reg & ~tgt_mask;
          ovr_b_reg <= ovr_b_reg & ~tgt_mask;
        end
        OP_LED_A: ovr_a_reg <= ovr_a_reg | tgt_mask;
        OP_LED_B: ovr_b_reg <= ovr_b_reg | tgt_mask;
        default:
        begin
          ovr_a_reg <= ovr_a_reg;
          ovr_b_reg <= ovr_b_reg;
        end
      endcase
    end
  end

  // Overridden drivers follow the shared blink phase, so the rate set last applies to both banks.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      led_a_reg <= '0;
      led_b_reg <= '0;
    end
    else
    begin
      led_a_reg <= (ovr_a_reg & {NUM_LED{lnk.blink_on}}) | (~ovr_a_reg & led_a_attr);
      led_b_reg <= (ovr_b_reg & {NUM_LED{lnk.blink_on}}) | (~ovr_b_reg & led_b_attr);
    end
  end

  // A flag event in the clearing cycle survives: the set term is applied after the clear.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_err_reg <= 1'b0;
      sqe_err_reg  <= 1'b0;
      loop_err_reg <= 1'b0;
    end
    else
    begin
      rate_err_reg <= aui_rate_err_evt
                      | (rate_err_reg & ~(status_cmd & lnk.cmd_byte[CMD_CLR_B_BIT]));
      sqe_err_reg  <= aui_sqe_err_evt
                      | (sqe_err_reg & ~(status_cmd & lnk.cmd_byte[CMD_CLR_SL_BIT]));
      loop_err_reg <= aui_loop_err_evt
                      | (loop_err_reg & ~(status_cmd & lnk.cmd_byte[CMD_CLR_SL_BIT]));
    end
  end

  always_comb
  begin
    attachment_status_flags             = 8'h00;
    attachment_status_flags[STAT_P_BIT] = aui_connected;
    attachment_status_flags[STAT_B_BIT] = rate_err_reg;
    attachment_status_flags[STAT_S_BIT] = sqe_err_reg;
    attachment_status_flags[STAT_L_BIT] = loop_err_reg;
  end

  assign lnk.rsp_load = status_cmd;
  assign lnk.rsp_byte = attachment_status_flags;
  assign lnk.rate     = rate_reg;

  assign link_test_en    = link_test_reg;
  assign link_pulse_en   = link_pulse_reg;
  assign pol_corr_en     = pol_corr_reg;
  assign ext_dist_en     = ext_dist_reg;
  assign pair_rx_invert  = rx_invert_reg;
  assign pair_disconnect = disconnect_reg;
  assign led_a_oe        = led_a_reg;
  assign led_b_oe        = led_b_reg;
  assign blink_rate      = rate_reg;

endmodule

`default_nettype wire

// ---- verification/rcp_ctrl_port_assertions.sv ----
// Concurrent checks on the ports of the control port command interpreter.
`default_nettype none

module rcp_ctrl_port_assertions
  import rcp_pkg::*;
(
  input wire logic                mclk,
  input wire logic                rst_b,
  input wire logic                ser_clk,
  input wire logic                ser_din,
  input wire logic                ser_sel_b,
  input wire logic                ser_dout,
  input wire logic [NUM_PAIR-1:0] pair_link_pass,
  input wire logic [NUM_PAIR-1:0] pair_pol_reversed,
  input wire logic                aui_connected,
  input wire logic                aui_rate_err_evt,
  input wire logic                aui_sqe_err_evt,
  input wire logic                aui_loop_err_evt,
  input wire logic [NUM_LED-1:0]  led_a_attr,
  input wire logic [NUM_LED-1:0]  led_b_attr,
  input wire logic [NUM_PAIR-1:0] link_test_en,
  input wire logic [NUM_PAIR-1:0] link_pulse_en,
  input wire logic [NUM_PAIR-1:0] pol_corr_en,
  input wire logic [NUM_PAIR-1:0] ext_dist_en,
  input wire logic [NUM_PAIR-1:0] pair_rx_invert,
  input wire logic [NUM_PAIR-1:0] pair_disconnect,
  input wire logic [NUM_LED-1:0]  led_a_oe,
  input wire logic [NUM_LED-1:0]  led_b_oe,
  input wire logic [1:0]          blink_rate
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] live_cnt;

  // Past values still reach into reset until a few edges have passed.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      live_cnt <= 2'h0;
    else if (live_cnt != 2'h3)
      live_cnt <= live_cnt + 2'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_reset_vals: assert property (live_cnt == 2'h1 |->
    blink_rate == 2'h0 && ext_dist_en == 4'h0 && link_test_en == 4'hf && link_pulse_en == 4'hf)
    else $error("option outputs wrong after reset");
  chk_disc_follow: assert property (live_cnt == 2'h3 |->
    pair_disconnect == ($past(link_test_en) & ~$past(pair_link_pass))) else $error("disconnect wrong");
  chk_cmd_only: assert property (live_cnt == 2'h3 && ($changed(blink_rate) || $changed(ext_dist_en)
    || $changed(link_pulse_en) || $changed(link_test_en)) |-> !$past(ser_sel_b, 2)) else $error("change off frame");
  chk_test_pair: assert property (live_cnt == 2'h3 && $changed(link_test_en) |->
    $onehot(link_test_en ^ $past(link_test_en))) else $error("link test changed several pairs");
  chk_pulse_pair: assert property (live_cnt == 2'h3 && $changed(link_pulse_en) |->
    $onehot(link_pulse_en ^ $past(link_pulse_en))) else $error("link pulse changed several pairs");
  chk_inv_corr: assert property (live_cnt == 2'h3 |->
    (pair_rx_invert & ~$past(pair_rx_invert) & ~$past(pol_corr_en)) == 4'h0) else $error("invert without correction");
  chk_led_off: assert property (live_cnt == 2'h3 && blink_rate == 2'h0 && $past(blink_rate, 3) == 2'h0 |->
    (led_a_oe & ~$past(led_a_attr)) == 6'h00 && (led_b_oe & ~$past(led_b_attr)) == 6'h00) else $error("led lit when off");
  chk_led_solid: assert property (live_cnt == 2'h3 && blink_rate == 2'h3 && $past(blink_rate, 3) == 2'h3 |->
    (~led_a_oe & $past(led_a_attr)) == 6'h00 && (~led_b_oe & $past(led_b_attr)) == 6'h00) else $error("led dark");
  chk_dout_frozen: assert property (live_cnt == 2'h3 && ser_sel_b && $past(ser_sel_b) |->
    $stable(ser_dout)) else $error("status output moved outside frame");
endmodule

`default_nettype wire

// ---- verification/rcp_host_model.sv ----
// Host controller model that drives the serial command port.
`default_nettype none

module rcp_host_model
(
  input  wire logic mclk,
  output logic      ser_clk,
  output logic      ser_din,
  output logic      ser_sel_b,
  input  wire logic ser_dout
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    ser_sel_b = 1'b1;
  end

  // Level held on the data line across reset release.
  task automatic set_din(input logic v);
    @(posedge mclk);
    ser_din <= v;
  endtask

  // The answer is taken well after the fall, never on the edge where it may move.
  task automatic bit_x(input logic d, output logic q);
    @(posedge mclk);
    ser_din <= d;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    q = ser_dout;
    @(posedge mclk);
    ser_clk <= 1'b1;
    repeat (2) @(posedge mclk);
    ser_clk <= 1'b0;
  endtask

  task automatic send(input logic [7:0] b, input int nb, input bit rd, output logic [7:0] rx);
    logic q;
    @(posedge mclk);
    ser_sel_b <= 1'b0;
    for (int i = 0; i < nb; i++)
      bit_x(b[i], q);
    for (int i = 0; i < 8 && rd; i++)
    begin
      bit_x(1'b0, q);
      rx[i] = q;
    end
    repeat (3) @(posedge mclk);
    ser_sel_b <= 1'b1;
    // A released data line does not keep its last level.
    ser_din <= ~ser_din;
  endtask
endmodule

`default_nettype wire

// ---- verification/rcp_ctrl_port_tb.sv ----
// Self-checking bench for the control port command interpreter.
`default_nettype none

module rcp_ctrl_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rcp_pkg::*;

  localparam int SLOW = 8;
  localparam int FAST = 20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  wire  ser_clk, ser_din, ser_sel_b;
  logic ser_dout, aui_conn = 1'b0, ev_b = 1'b0, ev_s = 1'b0, ev_l = 1'b0;
  logic [3:0] pass = 4'h0, pol_rev = 4'h0, lt, lp, pc, ed, inv, disc;
  logic [5:0] attr_a = 6'h00, attr_b = 6'h00, oe_a, oe_b, o_a, o_b;
  logic [1:0] rate, e_rate;
  logic [3:0] e_lt, e_lp, e_pc, e_ed;
  logic [7:0] rx;
  int error_cnt = 0;
  int compares = 0;

  always #25 mclk = ~mclk;

  rcp_host_model u_host (.mclk(mclk), .ser_clk(ser_clk), .ser_din(ser_din), .ser_sel_b(ser_sel_b),
    .ser_dout(ser_dout));
  rcp_ctrl_port #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) u_rcp_ctrl_port (.mclk(mclk), .rst_b(rst_b),
    .ser_clk(ser_clk), .ser_din(ser_din), .ser_sel_b(ser_sel_b), .ser_dout(ser_dout), .pair_link_pass(pass),
    .pair_pol_reversed(pol_rev), .aui_connected(aui_conn), .aui_rate_err_evt(ev_b), .aui_sqe_err_evt(ev_s),
    .aui_loop_err_evt(ev_l), .led_a_attr(attr_a), .led_b_attr(attr_b), .link_test_en(lt), .link_pulse_en(lp),
    .pol_corr_en(pc), .ext_dist_en(ed), .pair_rx_invert(inv), .pair_disconnect(disc), .led_a_oe(oe_a),
    .led_b_oe(oe_b), .blink_rate(rate));

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [5:0] tmask(input logic [3:0] t);
    case (t)
      4'h0, 4'h1, 4'h2, 4'h3: return 6'h01 << t;
      TGT_AUI: return 6'h10;
      TGT_ALL_PAIR: return 6'h0f;
      TGT_ALL: return 6'h1f;
      TGT_GLOBAL: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction

  function automatic void apply(input logic [7:0] b);
    case (b[7:2])
      6'h10: e_lt[b[1:0]] = 1'b0;
      6'h14: e_lt[b[1:0]] = 1'b1;
      6'h12: e_lp[b[1:0]] = 1'b0;
      6'h16: e_lp[b[1:0]] = 1'b1;
      6'h18: e_pc[b[1:0]] = 1'b0;
      6'h1c: e_pc[b[1:0]] = 1'b1;
      6'h1a: e_ed[b[1:0]] = 1'b0;
      6'h1e: e_ed[b[1:0]] = 1'b1;
      default: ;
    endcase
    case (b[7:4])
      OP_LED_OFF: {o_a, o_b} = {o_a & ~tmask(b[3:0]), o_b & ~tmask(b[3:0])};
      OP_LED_A: o_a = o_a | tmask(b[3:0]);
      OP_LED_B: o_b = o_b | tmask(b[3:0]);
      OP_RATE: e_rate = (b[3] && !b[2]) ? b[1:0] : e_rate;
      default: ;
    endcase
  endfunction

  task automatic do_reset(input logic strap);
    @(posedge mclk);
    rst_b <= 1'b0;
    u_host.set_din(strap);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    {e_lt, e_lp, e_pc, e_ed, e_rate, o_a, o_b} = {8'hff, {4{~strap}}, 4'h0, 2'h0, 12'h000};
    chk_v("pol_corr_en", {4'h0, e_pc}, {4'h0, pc});
  endtask

  task automatic cmd(input logic [7:0] b);
    u_host.send(b, 8, 1'b0, rx);
    apply(b);
    repeat (4) @(posedge mclk);
    chk_v("link_test_en", {4'h0, e_lt}, {4'h0, lt});
    chk_v("link_pulse_en", {4'h0, e_lp}, {4'h0, lp});
    chk_v("pol_corr_en", {4'h0, e_pc}, {4'h0, pc});
    chk_v("ext_dist_en", {4'h0, e_ed}, {4'h0, ed});
    chk_v("blink_rate", {6'h00, e_rate}, {6'h00, rate});
    chk_v("pair_disconnect", {4'h0, e_lt & ~pass}, {4'h0, disc});
    if (e_rate == 2'h0 || e_rate == 2'h3)
    begin
      chk_v("led_a_oe", {2'h0, e_rate[0] ? (o_a | attr_a) : (~o_a & attr_a)}, {2'h0, oe_a});
      chk_v("led_b_oe", {2'h0, e_rate[0] ? (o_b | attr_b) : (~o_b & attr_b)}, {2'h0, oe_b});
    end
  endtask

  task automatic blink_cnt(input int half);
    int n;
    n = 0;
    repeat (2 * half)
    begin
      @(negedge mclk);
      n += int'(oe_a[0]);
    end
    chk_v("blink_on_cycles", half[7:0], n[7:0]);
  endtask

  logic [5:0] ops [8] = '{6'h12, 6'h16, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h1e, 6'h1a};
  logic [7:0] leds [9] = '{8'heb, 8'hbd, 8'hc8, 8'h9e, 8'hbb, 8'h9c, 8'he8, 8'hb3, 8'h9d};
  logic [7:0] rds [4] = '{8'h89, 8'h8d, 8'h8b, 8'h8f};
  logic [7:0] rde [4] = '{8'hf0, 8'hf0, 8'hb0, 8'h80};

  initial
  begin
    void'($urandom(74468));
    do_reset(1'b1);
    do_reset(1'b0);
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 8; k++)
        cmd({ops[k], 2'(p)});
    foreach (leds[i])
      cmd(leds[i]);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge mclk);
      {pass, attr_a, attr_b} <= 16'($urandom);
      case ($urandom % 4)
        0: cmd({ops[$urandom % 8], 2'($urandom)});
        1: cmd({leds[$urandom % 3][7:4], 4'($urandom)});
        2: cmd({6'h3a, $urandom % 2 ? 2'h3 : 2'h0});
        default: cmd(8'($urandom));
      endcase
    end
    // A cut-off byte must not merge with the next one.
    u_host.send(8'hff, 4, 1'b0, rx);
    cmd(8'h49);
    cmd(8'h70);
    @(posedge mclk);
    pol_rev <= 4'h1;
    @(posedge mclk);
    pol_rev <= 4'h0;
    repeat (4) @(posedge mclk);
    chk_v("pair_rx_invert", 8'h01, {4'h0, inv});
    cmd(8'h60);
    chk_v("pair_rx_invert", 8'h00, {4'h0, inv});
    @(posedge mclk);
    {attr_a, aui_conn, ev_b, ev_s, ev_l} <= 10'h01f;
    @(posedge mclk);
    {ev_b, ev_s, ev_l} <= 3'h0;
    foreach (rds[i])
    begin
      u_host.send(rds[i], 8, 1'b1, rx);
      chk_v("status_byte", rde[i], rx);
    end
    aui_conn <= 1'b0;
    u_host.send(8'h8f, 8, 1'b1, rx);
    chk_v("status_byte", 8'h00, rx);
    cmd(8'he9);
    cmd(8'hb0);
    blink_cnt(SLOW);
    cmd(8'hea);
    blink_cnt(FAST);
    cmd(8'h9c);
    end_of_test();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    end_of_test();
  end
endmodule

bind rcp_ctrl_port rcp_ctrl_port_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .ser_clk(ser_clk),
  .ser_din(ser_din), .ser_sel_b(ser_sel_b), .ser_dout(ser_dout), .pair_link_pass(pair_link_pass),
  .pair_pol_reversed(pair_pol_reversed), .aui_connected(aui_connected), .aui_rate_err_evt(aui_rate_err_evt),
  .aui_sqe_err_evt(aui_sqe_err_evt), .aui_loop_err_evt(aui_loop_err_evt), .led_a_attr(led_a_attr),
  .led_b_attr(led_b_attr), .link_test_en(link_test_en), .link_pulse_en(link_pulse_en),
  .pol_corr_en(pol_corr_en), .ext_dist_en(ext_dist_en), .pair_rx_invert(pair_rx_invert),
  .pair_disconnect(pair_disconnect), .led_a_oe(led_a_oe), .led_b_oe(led_b_oe), .blink_rate(blink_rate));

`default_nettype wire
